// [common/io_expander_defs.svh]
/*
 * Constants for the I2C I/O expander: bus codes, reset values, timing.
 * Assumes a 20 MHz system clock that oversamples SCL and SDA.
 */
`ifndef IO_EXPANDER_DEFS_SVH
`define IO_EXPANDER_DEFS_SVH

`define GENCALL_ADDR      7'h00
`define SWRESET_BYTE      8'h06
`define PORT_RESET        8'hff
`define WRITE_BIT         1'b0
`define READ_BIT          1'b1
// Strap codes as sensed (ground, supply, clock line, data line)
`define STRAP_GND         2'h0
`define STRAP_VCC         2'h1
`define STRAP_SCL         2'h2
`define STRAP_SDA         2'h3
// Strap sense window after reset release, in system cycles
`define STRAP_SETTLE      8'h40

`endif

// [common/io_expander_pkg.sv]
/*
 * Types shared by the I/O expander design files.
 * Assumes the defines header is compiled alongside.
 */
`default_nettype none

package io_expander_pkg;

    // Serial engine states
    typedef enum logic [2:0] {
        IDLE,
        ADDR,
        ADDR_ACK,
        WR_DATA,
        WR_ACK,
        RD_DATA,
        RD_ACK
    } bus_state_t;

    // Both 8-bit port groups moving together
    typedef struct packed {
        logic [7:0] one;
        logic [7:0] zero;
    } port_pair_t;

    // Sensed code of one strap pin
    typedef logic [1:0] strap_t;

endpackage

`default_nettype wire

// [logic/pin_sync.sv]
/*
 * Two-flop synchroniser for a bundle of asynchronous pins.
 * Assumes inputs are unrelated to clock; stage one feeds stage two only.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // Pins
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);

    logic [W-1:0] stageOne;

    // Two stage capture
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stageOne <= '1;
            pinOut   <= '1;
        end
        else
        begin
            stageOne <= pinIn;
            pinOut   <= stageOne;
        end
    end

endmodule

`default_nettype wire

// [logic/i2c_quasi_bidir_io_expander.sv]
/*
 * I2C slave 16-bit quasi-bidirectional I/O expander with change interrupt.
 * Assumes SCL/SDA/pins are asynchronous and oversampled by a 20 MHz clock;
 * pads resolve open-drain levels from the output enables (low = driving).
 */
// What this block does
// - Slave address built from three four-state straps, 20h to EEh write.
// - Three straps select one of 64 addresses; no pull-ups on straps.
// - General call acknowledged only with write direction bit.
// - After general call, only byte 06h is acknowledged.
// - No further data bytes acknowledged within the reset sequence.
// - STOP after acknowledged 06h resets bus engine, port latches and interrupt, not strap sensing; repeated START does not.
// - Address LSB zero means write, one means read.
// - Unlimited write bytes alternate port 0 then port 1.
// - Written byte reaches port pins only after its acknowledge.
// - Read bytes alternate port 0 then port 1 while master reads.
// - Read bytes show live pin levels, not output latches.
// - STOP ends a read anytime; last acknowledge phase data holds.
// - After power-on all I/Os HIGH with weak source only.
// - Writing HIGH enables strong pull-up until next SCL falling edge.
// - Any port input edge asserts the active-low interrupt.
// - Interrupt clears on return to original data or device access.
// - On write, interrupt released by write strobe edges.
// - On read, interrupt cleared at read strobe rising edge.
// - Changes during clearing may be missed; later changes re-raise it.
// - Power-on reset initialises registers and bus state machine.
`timescale 1ns/1ps
`default_nettype none
`include "io_expander_defs.svh"

module i2c_quasi_bidir_io_expander (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // I2C bus
    input  wire logic                        scl,
    input  wire logic                        sdaIn,
    output logic                             sdaOe_n,
    // Address straps
    input  wire io_expander_pkg::strap_t     addr_strap_0,
    input  wire io_expander_pkg::strap_t     addr_strap_1,
    input  wire io_expander_pkg::strap_t     addr_strap_2,
    // Port pins
    input  wire io_expander_pkg::port_pair_t portIn,
    output io_expander_pkg::port_pair_t      portOe_n,
    output io_expander_pkg::port_pair_t      boost_pullup,
    // Interrupt, open drain
    output logic                             intOe_n
);
    import io_expander_pkg::*;

    logic       rstMeta;
    logic       rstSync;
    logic [1:0] busSync;
    port_pair_t pinSync;

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // Bus and port synchronisers
    pin_sync #(.W(2)) busSyncer (
        .clock  (clock),
        .rst_n  (rst_n),
        .pinIn  ({scl, sdaIn}),
        .pinOut (busSync)
    );
    pin_sync #(.W(16)) portSyncer (
        .clock  (clock),
        .rst_n  (rst_n),
        .pinIn  (portIn),
        .pinOut (pinSync)
    );

    wire sclNow = busSync[1];
    wire sdaNow = busSync[0];
    logic sclLast;
    logic sdaLast;
    logic swReset;

    // Edge and condition detection
    wire sclRise  = sclNow & ~sclLast;
    wire sclFall  = ~sclNow & sclLast;
    wire startSeen = sclNow & sclLast & sdaLast & ~sdaNow;
    wire stopSeen  = sclNow & sclLast & ~sdaLast & sdaNow;
    wire coreRst_n = rstSync & ~swReset;

    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            sclLast <= 1'b1;
            sdaLast <= 1'b1;
        end
        else
        begin
            sclLast <= sclNow;
            sdaLast <= sdaNow;
        end
    end

    // Strap sensing: a strap on SCL/SDA follows that line, so it is
    // classified by watching it against both lines over a settle window.
    strap_t     strapCode [3];
    logic [7:0] settleCount;
    logic [2:0] sawLow;
    logic [2:0] sawHigh;
    logic [2:0] diffScl;
    logic [2:0] diffSda;
    wire  [5:0] strapLevels = {addr_strap_2, addr_strap_1, addr_strap_0};
    wire        sensing     = settleCount != `STRAP_SETTLE;

    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            settleCount <= 8'h00;
            sawLow      <= 3'h0;
            sawHigh     <= 3'h0;
            diffScl     <= 3'h0;
            diffSda     <= 3'h0;
        end
        else if (sensing)
        begin
            settleCount <= settleCount + 8'h01;
            for (int i = 0; i < 3; i++)
            begin
                sawLow[i]  <= sawLow[i] | (strapLevels[2*i+:2] == `STRAP_GND);
                sawHigh[i] <= sawHigh[i] | (strapLevels[2*i+:2] == `STRAP_VCC);
                diffScl[i] <= diffScl[i] | (strapLevels[2*i+:2] != `STRAP_SCL);
                diffSda[i] <= diffSda[i] | (strapLevels[2*i+:2] != `STRAP_SDA);
            end
        end
    end

    function automatic strap_t classify(input logic low, input logic high,
                                        input logic nScl, input logic nSda);
        if (!nScl)
            classify = `STRAP_SCL;
        else if (!nSda)
            classify = `STRAP_SDA;
        else if (high && !low)
            classify = `STRAP_VCC;
        else
            classify = `STRAP_GND;
    endfunction

    assign strapCode[0] = classify(sawLow[0], sawHigh[0], diffScl[0], diffSda[0]);
    assign strapCode[1] = classify(sawLow[1], sawHigh[1], diffScl[1], diffSda[1]);
    assign strapCode[2] = classify(sawLow[2], sawHigh[2], diffScl[2], diffSda[2]);

    // Upper address nibble from which straps sit on bus lines
    function automatic logic [3:0] upperNibble(input logic [2:0] lines);
        unique case (lines)
            3'h0: upperNibble = 4'h4;
            3'h1: upperNibble = 4'h5;
            3'h2: upperNibble = 4'h2;
            3'h3: upperNibble = 4'h3;
            3'h4: upperNibble = 4'hc;
            3'h5: upperNibble = 4'he;
            3'h6: upperNibble = 4'ha;
            3'h7: upperNibble = 4'hb;
        endcase
    endfunction

    // Own address: line-strap nibble, then each strap's low code bit
    wire [6:0] ownAddr = {upperNibble({strapCode[2][1], strapCode[1][1], strapCode[0][1]}),
                          strapCode[2][0], strapCode[1][0], strapCode[0][0]};

    // Serial engine
    bus_state_t state;
    bus_state_t next_state;
    logic [7:0] shiftReg;
    logic [3:0] bitCount;
    logic       readMode;
    logic       genCall;
    logic       genByteSeen;
    logic       resetArmed;
    logic       portSel;
    logic       ackBit;
    port_pair_t outLatch;
    port_pair_t lastSeen;

    wire addrMatch = shiftReg[7:1] == ownAddr;
    // General call only with write direction
    wire gcMatch   = shiftReg[7:1] == `GENCALL_ADDR && shiftReg[0] == `WRITE_BIT;
    wire byteDone  = bitCount == 4'h8;
    // Only 06h, and only the first byte, is acknowledged
    wire gcAck     = shiftReg == `SWRESET_BYTE && !genByteSeen;
    // Port for the next read byte; the toggle at RD_ACK lands one edge late
    wire       nextSel  = (state == RD_ACK) ? ~portSel : portSel;
    wire [7:0] readByte = nextSel ? pinSync.one : pinSync.zero;

    // Next state on SCL falls
    always_comb
    begin
        next_state = state;
        unique case (state)
            IDLE:     next_state = IDLE;
            ADDR:     next_state = byteDone ? ((addrMatch || gcMatch) ? ADDR_ACK : IDLE) : ADDR;
            ADDR_ACK: next_state = readMode ? RD_DATA : WR_DATA;
            WR_DATA:  next_state = byteDone ? ((!genCall || gcAck) ? WR_ACK : IDLE) : WR_DATA;
            WR_ACK:   next_state = WR_DATA;
            RD_DATA:  next_state = byteDone ? RD_ACK : RD_DATA;
            RD_ACK:   next_state = ackBit ? IDLE : RD_DATA;
        endcase
    end

    wire ackPhase = state == ADDR_ACK || state == WR_ACK;

    always_ff @(posedge clock or negedge coreRst_n)
    begin
        if (!coreRst_n)
        begin
            state       <= IDLE;
            shiftReg    <= 8'h00;
            bitCount    <= 4'h0;
            readMode    <= 1'b0;
            genCall     <= 1'b0;
            genByteSeen <= 1'b0;
            resetArmed  <= 1'b0;
            portSel     <= 1'b0;
            ackBit      <= 1'b0;
            sdaOe_n     <= 1'b1;
        end
        else if (startSeen)
        begin
            // Repeated START cancels a pending reset
            state      <= ADDR;
            bitCount   <= 4'h0;
            resetArmed <= 1'b0;
            genCall    <= 1'b0;
            sdaOe_n    <= 1'b1;
        end
        else if (stopSeen)
        begin
            state   <= IDLE;
            sdaOe_n <= 1'b1;
        end
        else if (sclRise)
        begin
            if (state == ADDR || state == WR_DATA)
                shiftReg <= {shiftReg[6:0], sdaNow};
            bitCount <= (state == ADDR || state == WR_DATA || state == RD_DATA)
                        ? bitCount + 4'h1 : 4'h0;
            ackBit   <= sdaNow;
        end
        else if (sclFall)
        begin
            state    <= next_state;
            if (byteDone)
                bitCount <= 4'h0;
            if (state == ADDR && byteDone)
            begin
                readMode <= shiftReg[0] == `READ_BIT;
                genCall  <= gcMatch;
                genByteSeen <= 1'b0;
                portSel  <= 1'b0;
            end
            if (state == WR_DATA && byteDone && genCall)
            begin
                genByteSeen <= 1'b1;
                resetArmed  <= gcAck;
            end
            if (state == WR_ACK && !genCall)
                portSel <= ~portSel;
            if (next_state == ADDR_ACK || next_state == WR_ACK)
                sdaOe_n <= 1'b0;
            else if (next_state == RD_DATA)
                // Pins captured at the address or data acknowledge before each read byte
                sdaOe_n <= (state == RD_DATA ? shiftReg[7] : readByte[7]) ? 1'b1 : 1'b0;
            else
                sdaOe_n <= 1'b1;
            if (next_state == RD_DATA)
                shiftReg <= state == RD_DATA ? {shiftReg[6:0], 1'b1} : {readByte[6:0], 1'b1};
            if (state == RD_ACK)
                portSel <= ~portSel;
        end
    end

    // STOP after acknowledged 06h starts software reset
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            swReset <= 1'b0;
        else
            swReset <= stopSeen && resetArmed;
    end

    // Strobes: write lands at end of its acknowledge, read at address/data ack
    wire wrStrobe = sclFall && state == WR_ACK && !genCall;
    wire rdStrobe = sclFall && (state == ADDR_ACK || state == RD_ACK) && readMode;

    // Latch written byte once acknowledged, alternate ports
    // Latches reset HIGH so pins start as inputs
    always_ff @(posedge clock or negedge coreRst_n)
    begin
        if (!coreRst_n)
        begin
            outLatch     <= '{one: `PORT_RESET, zero: `PORT_RESET};
            boost_pullup <= '0;
            portOe_n     <= '1;
        end
        else
        begin
            if (wrStrobe && !portSel)
                outLatch.zero <= shiftReg;
            if (wrStrobe && portSel)
                outLatch.one  <= shiftReg;
            // Boost on pins written HIGH, dropped at next SCL fall
            if (wrStrobe && !portSel)
                boost_pullup.zero <= shiftReg;
            else if (wrStrobe && portSel)
                boost_pullup.one  <= shiftReg;
            else if (sclFall)
                boost_pullup <= '0;
            portOe_n <= wrStrobe ? (portSel ? port_pair_t'{one: shiftReg, zero: outLatch.zero}
                                            : port_pair_t'{one: outLatch.one, zero: shiftReg})
                                 : outLatch;
        end
    end

    // Reference captured at each access; any differing bit
    // Access resyncs reference, so interrupt releases
    // Changes after the strobe compare against the new reference
    wire changed = pinSync != lastSeen;

    always_ff @(posedge clock or negedge coreRst_n)
    begin
        if (!coreRst_n)
        begin
            lastSeen <= '{one: `PORT_RESET, zero: `PORT_RESET};
            intOe_n  <= 1'b1;
        end
        else
        begin
            if (wrStrobe || rdStrobe || sensing)
                lastSeen <= pinSync;
            intOe_n <= (wrStrobe || rdStrobe || sensing) ? 1'b1 : ~changed;
        end
    end

endmodule

`default_nettype wire

// [tb/io_expander_checker.sv]
/* Port checker for the I2C I/O expander, bound to its top module.
   Assumes the bench holds straps steady and moves pins on an idle bus. */
`timescale 1ns/1ps
`default_nettype none
module io_expander_checker (
    // Clock and reset
    input wire logic                        clock,
    input wire logic                        rst_n,
    // Bus
    input wire logic                        scl,
    input wire logic                        sdaIn,
    input wire logic                        sdaOe_n,
    // Pins and interrupt
    input wire io_expander_pkg::port_pair_t portIn,
    input wire io_expander_pkg::port_pair_t portOe_n,
    input wire io_expander_pkg::port_pair_t boost_pullup,
    input wire logic                        intOe_n
);
    import io_expander_pkg::*;
    logic [3:0] sinceChange;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Cycles since the pins last moved, saturating
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sinceChange <= 4'hf;
        else if ($changed(portIn))
            sinceChange <= 4'h0;
        else if (sinceChange != 4'hf)
            sinceChange <= sinceChange + 4'h1;
    end
    // Idle bus, and a lone pin edge while the clock rests high
    sequence busIdle;
        (scl && sdaIn)[*8];
    endsequence
    sequence quietEdge;
        scl[*8] ##0 (intOe_n && $changed(portIn) && sinceChange > 4'h8);
    endsequence
    reset_idle_a: assert property (disable iff (1'b0)
        !rst_n |-> sdaOe_n && intOe_n && portOe_n == '1 && boost_pullup == '0)
        else $error("outputs not idle in reset");
    boost_release_a: assert property (
        $fell(scl) && (|boost_pullup) |-> ##[1:6] (boost_pullup == '0))
        else $error("boost outlived the clock fall");
    boost_high_a: assert property (
        (|boost_pullup) |-> (boost_pullup & ~portOe_n) == '0)
        else $error("boost on a low pin");
    port_update_a: assert property (
        $changed(portOe_n) |-> !scl || portOe_n == '1)
        else $error("port moved with clock high");
    sda_drive_a: assert property (
        $changed(sdaOe_n) |-> !scl)
        else $error("data line moved with clock high");
    int_raise_a: assert property (
        quietEdge ##1 $stable(portIn)[*6] |-> !intOe_n)
        else $error("pin edge raised no interrupt");
    int_cause_a: assert property (
        $fell(intOe_n) |-> sinceChange < 4'h8)
        else $error("interrupt without a pin edge");
    port_hold_a: assert property (
        busIdle |-> $stable(portOe_n) && $stable(sdaOe_n))
        else $error("outputs moved on an idle bus");
endmodule
bind i2c_quasi_bidir_io_expander io_expander_checker u_io_expander_checker (
    .clock(clock), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .sdaOe_n(sdaOe_n),
    .portIn(portIn), .portOe_n(portOe_n), .boost_pullup(boost_pullup),
    .intOe_n(intOe_n));
`default_nettype wire

// [tb/i2c_master_model.sv]
/* Behavioural I2C master: START, STOP and byte transfers.
   Assumes the bench resolves SDA with a pull-up; SCL rests high. */
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    // Bus lines
    output logic     scl,
    output logic     sdaLow,
    input wire logic sdaWire
);
    // Idle bus
    initial
    begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // START or repeated START, leaves the clock low
    task automatic startCond();
        sdaLow = 1'b0;
        #130;
        scl = 1'b1;
        #140;
        sdaLow = 1'b1;
        #140;
        scl = 1'b0;
        #130;
    endtask
    // STOP, then the clock stands high
    task automatic stopCond();
        sdaLow = 1'b1;
        #130;
        scl = 1'b1;
        #140;
        sdaLow = 1'b0;
        #400;
    endtask
    // One bit: set mid-low, sampled mid-high
    task automatic bitXfer(input logic b, output logic r);
        sdaLow = !b;
        #130;
        scl = 1'b1;
        #70;
        r = sdaWire;
        #70;
        scl = 1'b0;
        #130;
    endtask
    // MSB first
    // Eight bits then the ninth; ackBit 1 releases the line
    task automatic xfer(input logic [7:0] d, input logic ackBit,
                        output logic [7:0] q, output logic ackSeen);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitXfer(d[i], q[i]);
        bitXfer(ackBit, r);
        ackSeen = !r;
    endtask
endmodule
`default_nettype wire

// [tb/i2c_quasi_bidir_io_expander_tb.sv]
/* Bench for the I2C I/O expander: master model, pin model, checks.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
module i2c_quasi_bidir_io_expander_tb;
    import io_expander_pkg::*;
    logic        clock;
    logic        rst_n;
    logic        scl;
    logic        sdaLow;
    logic        sdaWire;
    logic        sdaOe_n;
    logic        intOe_n;
    logic        ack;
    logic [7:0]  q;
    logic [7:0]  addr;
    logic [23:0] d;
    strap_t      strap [3];
    port_pair_t  ext;
    port_pair_t  latch;
    port_pair_t  want;
    port_pair_t  pins;
    port_pair_t  portOe_n;
    port_pair_t  boost;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    integer      seed = 32'he9810343;
    // Open-drain data line with pull-up; latch low pulls a pin low
    assign sdaWire = sdaOe_n && !sdaLow;
    assign pins    = portOe_n & ext;
    i2c_quasi_bidir_io_expander u_i2c_quasi_bidir_io_expander (
        .clock(clock), .rst_n(rst_n), .scl(scl), .sdaIn(sdaWire), .sdaOe_n(sdaOe_n),
        .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
        .portIn(pins), .portOe_n(portOe_n), .boost_pullup(boost), .intOe_n(intOe_n));
    i2c_master_model u_i2c_master_model (.scl(scl), .sdaLow(sdaLow), .sdaWire(sdaWire));
    // Clock
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Write address from the strap codes
    function automatic logic [7:0] addrOf(input strap_t s2, input strap_t s1, input strap_t s0);
        logic [7:0] base [8] = '{8'h40, 8'h50, 8'h20, 8'h30, 8'hc0, 8'he0, 8'ha0, 8'hb0};
        return base[{s2[1], s1[1], s0[1]}] | {4'h0, s2[0], s1[0], s0[0], 1'b0};
    endfunction
    task automatic doReset(input logic [5:0] s);
        @(negedge clock);
        rst_n = 1'b0;
        {strap[2], strap[1], strap[0]} = s;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (80) @(negedge clock);
    endtask
    task automatic sendAddr(input logic [7:0] a);
        u_i2c_master_model.startCond();
        u_i2c_master_model.xfer(a, 1'b1, q, ack);
    endtask
    task automatic wrByte(input logic [7:0] b);
        u_i2c_master_model.xfer(b, 1'b1, q, ack);
    endtask
    task automatic writePair(input logic [15:0] v);
        sendAddr(addr);
        check("ack addr", {15'h0, ack}, 16'h1);
        wrByte(v[7:0]);
        wrByte(v[15:8]);
        u_i2c_master_model.stopCond();
    endtask
    task automatic gcByte(input logic [7:0] b, input logic exp);
        sendAddr(8'h00);
        check("gc ack", {15'h0, ack}, 16'h1);
        wrByte(b);
        check("gc byte", {15'h0, ack}, {15'h0, exp});
    endtask
    // Main sequence
    initial
    begin
        rst_n = 1'b1;
        {strap[2], strap[1], strap[0]} = 6'h00;
        ext = '1;
        latch = '1;
        for (int it = 0; it < 4; it++)
        begin
            doReset((it == 0) ? 6'h00 : (it == 1) ? 6'h37 : 6'($random(seed)));
            addr = addrOf(strap[2], strap[1], strap[0]);
            sendAddr(addr ^ 8'h02);
            u_i2c_master_model.stopCond();
            check("ack other", {15'h0, ack}, 16'h0);
            // Three bytes: zero, one, zero again
            sendAddr(addr);
            check("ack write", {15'h0, ack}, 16'h1);
            d = 24'($random(seed));
            wrByte(d[23:16]);
            repeat (4) @(negedge clock);
            check("port zero", portOe_n, {8'hff, d[23:16]});
            wrByte(d[15:8]);
            wrByte(d[7:0]);
            check("ack data", {15'h0, ack}, 16'h1);
            u_i2c_master_model.stopCond();
            latch = d[15:0];
            check("port pair", portOe_n, latch);
            // Live pin levels read back in pairs
            @(negedge clock);
            ext = 16'($random(seed));
            want = latch & ext;
            repeat (12) @(negedge clock);
            sendAddr(addr | 8'h01);
            check("ack read", {15'h0, ack}, 16'h1);
            for (int k = 0; k < 4; k++)
            begin
                u_i2c_master_model.xfer(8'hff, k == 3, q, ack);
                check("read byte", {8'h0, q}, {8'h0, k[0] ? want.one : want.zero});
            end
            u_i2c_master_model.stopCond();
            check("int read", {15'h0, intOe_n}, 16'h1);
            // Software reset: refusals, aborts, then the real one
            sendAddr(8'h01);
            u_i2c_master_model.stopCond();
            check("gc read", {15'h0, ack}, 16'h0);
            gcByte(8'h07 + 8'(it), 1'b0);
            u_i2c_master_model.stopCond();
            gcByte(8'h06, 1'b1);
            wrByte(8'h06);
            check("extra byte", {15'h0, ack}, 16'h0);
            u_i2c_master_model.stopCond();
            check("aborted", portOe_n, latch);
            gcByte(8'h06, 1'b1);
            u_i2c_master_model.startCond();
            u_i2c_master_model.stopCond();
            check("rep start", portOe_n, latch);
            gcByte(8'h06, 1'b1);
            u_i2c_master_model.stopCond();
            latch = '1;
            check("sw reset", portOe_n, latch);
            // Interrupt: raise, revert, raise, clear by write
            // inputs written HIGH, each port written whole
            writePair(16'hffff);
            for (int k = 0; k < 3; k++)
            begin
                @(negedge clock);
                ext[it * 5] = ~ext[it * 5];
                repeat (12) @(negedge clock);
                check("int level", {15'h0, intOe_n}, {15'h0, k[0]});
            end
            writePair(16'hffff);
            check("int write", {15'h0, intOe_n}, 16'h1);
        end
        test_done();
    end
endmodule
`default_nettype wire
